// [rtl/mdioa_pkg.sv]
/*
  Constants, field layouts and types for the digital I/O adapter.
  Assumes a 125 MHz clock and an APB master issuing host operations.
*/
// Contract
// R1 - Decode the 16-bit address only when its top four bits are 1100.
// R2 - Three unit bits pick one of eight adapters; act only on own unit.
// R3 - Half bit picks upper or lower byte of a 16-bit input module.
// R4 - Four group bits pick one group of four modules, up to 15 groups.
// R5 - Byte enables pick modules in the group; 1111 means a full word.
// R6 - A 16-bit host uses byte enables 0011 or 1100 only.
// R7 - Writes load selected stored-output bytes, held on output lines.
// R8 - After a load, strobe each loaded byte.
// R9 - Writes to pulsed modules pulse each line whose data bit is one.
// R10 - Reads gate 16 or 32 selected input lines to the host.
// R11 - Host writes output modules and reads input modules.
// R12 - Grounded feedback blocks alteration on write and returns status 11.
// R13 - Pulses and strobes last one to four selectable microseconds.
// R14 - Pulsed module feedback ends its pulse early.
// R15 - Status 10 input, 01 output, 11 rejected, 00 nothing installed.
// R16 - Each connector has four data bytes, each with strobe and feedback.
// R17 - Host gives address, direction and, on writes, data.
// R18 - Unselected or inhibited holding registers keep their contents.
package mdioa_pkg;
  localparam logic [7:0] OFS_ADDR       = 8'h00;
  localparam logic [7:0] OFS_WDATA      = 8'h04;
  localparam logic [7:0] OFS_RDATA      = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_CONFIG     = 8'h10;
  localparam int         CMD_WRITE_BIT  = 16;
  localparam int         STAT_BUSY_BIT  = 2;
  localparam int         CFG_WIDTH_LSB  = 4;
  localparam logic [31:0] CONFIG_RESET  = 32'h0000_0000;
  localparam logic [3:0] ADDR_PREFIX    = 4'hC;
  localparam logic [1:0] ST_NONE        = 2'b00;
  localparam logic [1:0] ST_OUTPUT      = 2'b01;
  localparam logic [1:0] ST_INPUT       = 2'b10;
  localparam logic [1:0] ST_REJECT      = 2'b11;
  localparam logic [1:0] MT_NONE        = 2'd0;
  localparam logic [1:0] MT_STORED      = 2'd1;
  localparam logic [1:0] MT_INPUT       = 2'd2;
  localparam logic [1:0] MT_PULSED      = 2'd3;
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         PULSE_UNIT_NS  = 1000;
  localparam int         PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PULSE_CNT_W    = 9;

  typedef struct packed {
    logic [3:0] prefix;
    logic [2:0] unit;
    logic       half;
    logic [3:0] group;
    logic [3:0] bytes;
  } mdioa_addr_s;

  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_PULSE} mdioa_state_e;

  function automatic logic [PULSE_CNT_W-1:0] mdioa_pulse_cycles(input logic [1:0] sel);
    pulse_cycles_calc: begin
    end
    return PULSE_CNT_W'((int'(sel) + 1) * PULSE_UNIT_CYC);
  endfunction : mdioa_pulse_cycles
endpackage : mdioa_pkg

// [rtl/mdioa_top.sv]
/*
  Digital I/O adapter: APB register front end, address decode, stored outputs
  with strobes, pulsed outputs, input sensing, feedback inhibit and status.
  Assumes the external data and feedback pins are asynchronous to ref_clk.
*/
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module mdioa_top
  import mdioa_pkg::*;
#(
  parameter int                 NGRP     = 15,
  parameter logic [NGRP*8-1:0]  MOD_TYPE = {(NGRP*2){4'b1001}}
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NGRP*64-1:0]   data_in,
  input  wire logic [NGRP*4-1:0]    feedback_n,
  output logic      [NGRP*32-1:0]   data_out,
  output logic      [NGRP*4-1:0]    strobe
);
  localparam int NMOD = NGRP * 4;

  // pin synchroniser group
  logic [NMOD*16-1:0] din_s1_q, din_s2_q, din_s3_q, din_q, din_d;
  logic [NMOD-1:0]    fb_s1_q, fb_s2_q, fb_s3_q, fb_n_q, fb_n_d;

  always_comb begin
    // a change is accepted only once the last two stages agree
    din_d  = (~(din_s2_q ^ din_s3_q) & din_s3_q) | ((din_s2_q ^ din_s3_q) & din_q);
    fb_n_d = (~(fb_s2_q ^ fb_s3_q) & fb_s3_q) | ((fb_s2_q ^ fb_s3_q) & fb_n_q);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      din_s3_q <= '0;
      din_q    <= '0;
      fb_s1_q  <= '1;
      fb_s2_q  <= '1;
      fb_s3_q  <= '1;
      fb_n_q   <= '1;
    end else if (ce) begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      din_q    <= din_d;
      fb_s1_q  <= feedback_n;
      fb_s2_q  <= fb_s1_q;
      fb_s3_q  <= fb_s2_q;
      fb_n_q   <= fb_n_d;
    end
  end

  // main group
  mdioa_state_e           state_q, state_d;
  logic [31:0]            prdata_q, prdata_d, wdata_q, wdata_d, cfg_q, cfg_d;
  logic [31:0]            rdata_q, rdata_d;
  logic                   pready_q, pready_d, pslverr_q, pslverr_d;
  logic [1:0]             status_q, status_d;
  logic [NMOD*8-1:0]      out_q, out_d, pdata_q, pdata_d;
  logic [NMOD-1:0]        strobe_q, strobe_d, smask_q, smask_d, pmask_q, pmask_d;
  logic [PULSE_CNT_W-1:0] cnt_q, cnt_d, width_cyc;
  mdioa_addr_s            op_addr;
  logic                   acc, op_fire, op_wr, op_match, op_rej, any_in, any_out, stall;
  logic                   mapped;
  logic [31:0]            rd_word;
  logic [7:0]             wbyte;
  int                     m;

  function automatic logic [1:0] mod_type(input int idx);
    return MOD_TYPE[idx*2 +: 2];
  endfunction : mod_type

  // lowest pulsed module, or 0 when none is fitted; the cut check watches it
  function automatic int first_pulsed();
    int idx;
    idx = 0;
    for (int i = NMOD - 1; i >= 0; i--) begin
      if (MOD_TYPE[i*2 +: 2] == MT_PULSED) begin
        idx = i;
      end
    end
    return idx;
  endfunction : first_pulsed

  localparam int PMOD = first_pulsed();

  assign width_cyc = mdioa_pulse_cycles(cfg_q[CFG_WIDTH_LSB +: 2]);

  always_comb begin
    state_d   = state_q;
    prdata_d  = prdata_q;
    wdata_d   = wdata_q;
    cfg_d     = cfg_q;
    rdata_d   = rdata_q;
    status_d  = status_q;
    out_d     = out_q;
    pdata_d   = pdata_q;
    strobe_d  = strobe_q;
    smask_d   = smask_q;
    pmask_d   = pmask_q;
    cnt_d     = cnt_q;
    op_rej    = 1'b0;
    any_in    = 1'b0;
    any_out   = 1'b0;
    rd_word   = 32'h0000_0000;
    m         = 0;
    wbyte     = 8'h00;
    acc       = psel && penable;
    op_addr   = mdioa_addr_s'(pwdata[15:0]);
    op_wr     = pwdata[CMD_WRITE_BIT];
    mapped    = (paddr == OFS_ADDR) || (paddr == OFS_WDATA) || (paddr == OFS_RDATA) ||
                (paddr == OFS_STATUS) || (paddr == OFS_CONFIG);
    // a new operation waits for the previous pulses to finish
    stall     = pwrite && (paddr == OFS_ADDR) && (state_q != S_IDLE);
    op_fire   = acc && pready_q && pwrite && (paddr == OFS_ADDR);
    op_match  = (op_addr.prefix == ADDR_PREFIX) && (op_addr.unit == cfg_q[2:0]) && // [R1] [R2]
                (int'(op_addr.group) < NGRP); // [R4]
    pready_d  = acc && !pready_q && !stall;
    pslverr_d = acc && !pready_q && !stall && !mapped;
    if (acc && !pready_q && !pwrite) begin
      case (paddr)
        OFS_WDATA:  prdata_d = wdata_q;
        OFS_RDATA:  prdata_d = rdata_q;
        OFS_STATUS: prdata_d = {29'h0, (state_q != S_IDLE), status_q};
        OFS_CONFIG: prdata_d = cfg_q;
        default:    prdata_d = 32'h0000_0000;
      endcase
    end
    if (acc && pready_q && pwrite) begin
      case (paddr)
        OFS_WDATA:  wdata_d = pwdata;
        OFS_CONFIG: cfg_d   = pwdata;
        default:    cfg_d   = cfg_q;
      endcase
    end
    if (op_fire) begin
      smask_d = '0;
      pmask_d = '0;
      for (int b = 0; b < 4; b++) begin
        m     = int'(op_addr.group) * 4 + b;
        wbyte = wdata_q[31-8*b -: 8];
        if (op_match && op_addr.bytes[3-b] && mod_type(m) != MT_NONE) begin // [R5]
          if (mod_type(m) == MT_INPUT) begin
            any_in = 1'b1;
          end else begin
            any_out = 1'b1;
          end
          if (op_wr) begin
            if (mod_type(m) != MT_PULSED && !fb_n_q[m]) begin
              op_rej = 1'b1; // [R12] [R18]
            end else if (mod_type(m) == MT_STORED) begin
              out_d[m*8 +: 8] = wbyte; // [R7]
              smask_d[m]      = 1'b1;
            end else if (mod_type(m) == MT_PULSED) begin
              pdata_d[m*8 +: 8] = wbyte; // [R9]
              pmask_d[m]        = 1'b1;
            end
          end else if (mod_type(m) == MT_INPUT) begin
            rd_word[31-8*b -: 8] = op_addr.half ? din_q[m*16+8 +: 8] : din_q[m*16 +: 8]; // [R3] [R10]
          end
        end
      end
      rdata_d = rd_word;
      if (op_rej) begin // [R15]
        status_d = ST_REJECT;
      end else if (any_in) begin
        status_d = ST_INPUT;
      end else if (any_out) begin
        status_d = ST_OUTPUT;
      end else begin
        status_d = ST_NONE;
      end
      if (|smask_d || |pmask_d) begin
        state_d = S_LOAD;
      end
    end
    case (state_q)
      S_IDLE: begin
        state_d = state_d;
      end
      S_LOAD: begin
        strobe_d = smask_q; // [R8]
        for (int k = 0; k < NMOD; k++) begin
          if (pmask_q[k]) begin
            out_d[k*8 +: 8] = pdata_q[k*8 +: 8]; // [R9]
          end
        end
        cnt_d   = width_cyc - PULSE_CNT_W'(1); // [R13]
        state_d = S_PULSE;
      end
      S_PULSE: begin
        for (int k = 0; k < NMOD; k++) begin
          if (pmask_q[k] && (!fb_n_q[k] || cnt_q == '0)) begin
            out_d[k*8 +: 8] = 8'h00; // [R14]
          end
        end
        if (cnt_q == '0) begin
          strobe_d = '0; // [R13]
          state_d  = S_IDLE;
        end else begin
          cnt_d = cnt_q - PULSE_CNT_W'(1);
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q   <= S_IDLE;
      prdata_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      cfg_q     <= CONFIG_RESET;
      rdata_q   <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      status_q  <= ST_NONE;
      out_q     <= '0;
      pdata_q   <= '0;
      strobe_q  <= '0;
      smask_q   <= '0;
      pmask_q   <= '0;
      cnt_q     <= '0;
    end else if (ce) begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      wdata_q   <= wdata_d;
      cfg_q     <= cfg_d;
      rdata_q   <= rdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      status_q  <= status_d;
      out_q     <= out_d;
      pdata_q   <= pdata_d;
      strobe_q  <= strobe_d;
      smask_q   <= smask_d;
      pmask_q   <= pmask_d;
      cnt_q     <= cnt_d;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign data_out = out_q; // [R16]
  assign strobe   = strobe_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !ce);

  sequence load_step;
    state_q == S_LOAD;
  endsequence

  sequence pulse_last;
    state_q == S_PULSE && cnt_q == '0;
  endsequence

  prefix_gate_a: assert property (op_fire && op_addr.prefix != ADDR_PREFIX |=> // [R1]
    status_q == ST_NONE && rdata_q == 32'h0000_0000) else $error("wrong prefix decoded");
  unit_gate_a: assert property (op_fire && op_addr.unit != cfg_q[2:0] |=> // [R2]
    status_q == ST_NONE && $stable(out_q)) else $error("foreign unit acted on");
  reject_code_a: assert property (op_fire && op_rej |=> status_q == ST_REJECT) // [R12]
    else $error("rejection not reported");
  hold_idle_a: assert property (state_q == S_IDLE && !op_fire |=> $stable(out_q)) // [R18]
    else $error("holding register changed");
  strobe_load_a: assert property (load_step |=> strobe_q == smask_q && state_q == S_PULSE) // [R8]
    else $error("strobe not issued after load");
  width_load_a: assert property (load_step |=> cnt_q == $past(width_cyc) - PULSE_CNT_W'(1)) // [R13]
    else $error("pulse width count wrong");
  pulse_end_a: assert property (pulse_last |=> strobe_q == '0 && state_q == S_IDLE) // [R13]
    else $error("pulse did not end");
  fb_cut_a: assert property (state_q == S_PULSE && pmask_q[PMOD] && !fb_n_q[PMOD] |=> // [R14]
    out_q[PMOD*8 +: 8] == 8'h00) else $error("feedback did not end pulse");
  apb_answer_a: assert property (acc && !pready_q && !stall |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");
  // bus handshake and hold checks
  stall_wait_a: assert property (acc && stall |=> !pready_q)
    else $error("busy operation answered early");
  err_pair_a: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  prdata_hold_a: assert property (!(acc && !pready_q && !pwrite) |=> $stable(prdata_q))
    else $error("read data changed without read");
  input_code_a: assert property (op_fire && !op_wr && any_in |=> status_q == ST_INPUT) // [R15]
    else $error("input status not reported");
  read_quiet_a: assert property (op_fire && !op_wr |=> $stable(out_q) && state_q == S_IDLE) // [R10]
    else $error("read altered outputs");
  reject_hold_a: assert property (op_fire && op_rej && !(|smask_d || |pmask_d) |=> // [R18]
    $stable(out_q)) else $error("rejected module altered");
  strobe_idle_a: assert property (state_q == S_IDLE |-> strobe_q == '0) // [R13]
    else $error("strobe outside pulse");
  strobe_span_a: assert property (state_q == S_PULSE |-> strobe_q == smask_q) // [R8]
    else $error("strobe dropped during pulse");
endmodule : mdioa_top
`default_nettype wire

// [testbench/mdioa_ext.sv]
/*
  External units on the connectors: drive input lines and feedback.
  Assumes the bench sets line patterns and feedback levels.
*/
`timescale 1ns/100ps
`default_nettype none
module mdioa_ext #(
  parameter int NG = 2
) (
  input  wire logic              ref_clk,
  input  wire logic [NG*64-1:0]  pat,
  input  wire logic [NG*4-1:0]   fb_set_n,
  output logic      [NG*64-1:0]  data_in,
  output logic      [NG*4-1:0]   feedback_n
);
  // feedback is open collector; released lines sit high
  initial begin
    feedback_n = '1;
    data_in    = '0;
    forever begin
      @(posedge ref_clk);
      data_in    <= pat;
      feedback_n <= fb_set_n;
    end
  end
endmodule : mdioa_ext
`default_nettype wire

// [testbench/tb_top.sv]
/*
  Self-checking bench for the digital I/O adapter over APB.
  Assumes two groups with a fixed mix of module types.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mdioa_pkg::*;
  localparam int              NG = 2;
  localparam logic [NG*8-1:0] MT = 16'hCA79;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic [NG*64-1:0] data_in, in_pat = '0;
  logic [NG*4-1:0]  feedback_n, strobe, fb_set_n = '1;
  logic [NG*32-1:0] data_out, exp_out = '0, smask = '0;
  int mismatches = 0, total_checks = 0, cyc = 0, seed = 32'h71865EA5, n;
  logic [31:0] r;
  always #4 ref_clk = ~ref_clk;
  mdioa_top #(.NGRP(NG), .MOD_TYPE(MT)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
    .feedback_n(feedback_n), .data_out(data_out), .strobe(strobe));
  mdioa_ext #(.NG(NG)) ext (.ref_clk(ref_clk), .pat(in_pat), .fb_set_n(fb_set_n),
    .data_in(data_in), .feedback_n(feedback_n));
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // generous ceiling: the longest test is under 5000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 40000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle count assumed; the bench ceiling ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [1:0] exp_st(logic w, logic [3:0] g, logic [3:0] be,
                                        logic [NG*4-1:0] fbn);
    logic rj, ip, op;
    int m;
    logic [1:0] t;
    rj = 0; ip = 0; op = 0;
    for (int b = 0; b < 4; b++) begin
      m = g * 4 + b;
      t = (g < NG) ? MT[m*2+:2] : MT_NONE;
      if (be[3-b] && t != MT_NONE) begin
        if (w && !fbn[m] && t != MT_PULSED) rj = 1;
        if (t == MT_INPUT) ip = 1;
        else op = 1;
      end
    end
    return rj ? ST_REJECT : ip ? ST_INPUT : op ? ST_OUTPUT : ST_NONE;
  endfunction : exp_st
  task automatic do_op(input logic w, input logic [3:0] pf, input logic [2:0] u,
                       input logic [3:0] g, input logic [3:0] be, input logic h,
                       input logic [31:0] d);
    logic [1:0]  es;
    logic [31:0] er;
    logic [1:0]  t;
    int          m;
    logic        ok;
    ok = (pf == ADDR_PREFIX) && (u == 3'd0) && (g < NG);
    es = ok ? exp_st(w, g, be, fb_set_n) : ST_NONE;
    er = '0;
    for (int b = 0; b < 4; b++) begin
      m = g * 4 + b;
      t = ok ? MT[m*2+:2] : MT_NONE;
      if (be[3-b] && !w && t == MT_INPUT) er[31-8*b-:8] = in_pat[m*16+8*h+:8];
      if (be[3-b] && w && t == MT_STORED && fb_set_n[m]) exp_out[m*8+:8] = d[31-8*b-:8];
    end
    apb(1'b1, OFS_WDATA, d);
    apb(1'b1, OFS_ADDR, {15'h0, w, pf, u, h, g, be});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", es, rd[1:0]);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", er, rd);
    chk("stored_out", exp_out & smask, data_out & smask);
  endtask : do_op
  initial begin
    for (int m = 0; m < NG * 4; m++) if (MT[m*2+:2] == MT_STORED) smask[m*8+:8] = 8'hFF;
    for (int i = 0; i < NG * 2; i++) in_pat[i*32+:32] = $random(seed);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 1'b1, err);
    do_op(1'b1, 4'hC, 3'd0, 4'h0, 4'hF, 1'b0, 32'h5AC3_0F81);
    do_op(1'b0, 4'hC, 3'd0, 4'h1, 4'hC, 1'b1, 32'h0);
    do_op(1'b1, 4'hC, 3'd0, 4'h0, 4'h3, 1'b0, 32'h0000_5A3C);
    do_op(1'b1, 4'h8, 3'd0, 4'h0, 4'hF, 1'b0, 32'h1111_1111);
    do_op(1'b1, 4'hC, 3'd1, 4'h0, 4'hF, 1'b0, 32'h2222_2222);
    do_op(1'b1, 4'hC, 3'd0, 4'h2, 4'hF, 1'b0, 32'h3333_3333);
    $display("test decode done");
    for (int i = 0; i < 16; i++) begin
      fb_set_n <= (NG*4)'($random(seed) | $random(seed));
      repeat (5) @(posedge ref_clk);
      r = $random(seed);
      do_op(r[0], 4'hC, 3'd0, {3'b0, r[1]}, r[5:2], r[6], $random(seed));
    end
    fb_set_n <= '1;
    $display("test random done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CONFIG, 32'(s) << CFG_WIDTH_LSB);
      apb(1'b1, OFS_WDATA, 32'hC300_0000);
      apb(1'b1, OFS_ADDR, {15'h0, 1'b1, 16'hC008});
      @(posedge ref_clk);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (strobe[0] === 1'b1 && n < 600);
      chk("strobe_width", (s + 1) * 125, n - 1);
    end
    $display("test width done");
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b1, OFS_WDATA, 32'h0000_A500);
    apb(1'b1, OFS_ADDR, {15'h0, 1'b1, 16'hC002});
    repeat (3) @(posedge ref_clk);
    chk("pulse_bits", 8'hA5, data_out[23:16]);
    repeat (10) @(posedge ref_clk);
    fb_set_n[2] <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (data_out[23:16] !== 8'h00 && n < 20);
    // four sync flops, the pad flop and one cycle to clear
    chk("early_end", 1'b1, n <= 8);
    fb_set_n <= '1;
    $display("test pulse done");
    // a clock-enable gap of ten cycles stretches the strobe by as much
    apb(1'b1, OFS_ADDR, {15'h0, 1'b1, 16'hC008});
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      if (strobe[0] === 1'b1) n++;
      if (i == 20) ce <= 1'b0;
      if (i == 30) ce <= 1'b1;
    end
    chk("freeze_width", PULSE_UNIT_CYC + 10, n);
    $display("test freeze done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
